// >>> verilog/rfdc_pkg.sv
package rfdc_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 40;
   localparam int T_PRE_TYP_US = 20;
   localparam int T_PRE_TYP_CYC = T_PRE_TYP_US * CLK_MHZ;
   localparam int POWER_TRANSITION_TIME_US = 22;
   localparam int POWER_TRANSITION_TIME_CYC = POWER_TRANSITION_TIME_US * CLK_MHZ;
   localparam logic [15:0] POWER_TRANSITION_TIME_C = 16'(POWER_TRANSITION_TIME_CYC);
   localparam int SETTLE_CYC_DEF = 64;
   // ****************************************
   // Limits and reset values
   // ****************************************
   localparam int MAX_DEV_MHZ = 1000;
   localparam logic [9:0] MAX_DEV = 10'(MAX_DEV_MHZ);
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [9:0] FREQ_RST = 10'h000;
   localparam logic [3:0] ZONE_RST = 4'h0;
   localparam logic [8:0] WIN_UNITY = 9'h100;
   localparam logic [8:0] HAMM_PED = 9'h014;
   localparam logic [8:0] HAMM_SLOPE = 9'h0ec;
   localparam int HPF_SHIFT = 4;
   localparam logic [2:0] DOP_LAST = 3'h4;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {RFDC_CH_UART, RFDC_CH_I2C, RFDC_CH_SPI, RFDC_CH_RSVD} rfdc_chan_t;
   typedef enum logic [1:0] {RFDC_FMT_DECIMATED_RAW, RFDC_FMT_RANGE, RFDC_FMT_DOPPLER, RFDC_FMT_CFAR} rfdc_fmt_t;
   typedef enum logic [1:0] {RFDC_DEC_1, RFDC_DEC_2, RFDC_DEC_4, RFDC_DEC_8} rfdc_dec_t;
   typedef enum logic [1:0] {RFDC_WIN_HANN, RFDC_WIN_HAMM, RFDC_WIN_BLACK, RFDC_WIN_RECT} rfdc_win_t;
   typedef enum logic [1:0] {RFDC_RSZ_64, RFDC_RSZ_128, RFDC_RSZ_256, RFDC_RSZ_BAD} rfdc_rsz_t;
   typedef enum logic [2:0] {FR_HALT, FR_PRE, FR_CHIRP, FR_IDLE} rfdc_frame_t;
endpackage

// >>> verilog/rfdc_top.sv

// ****************************************
// Sample buffer
// ****************************************
module rfdc_fifo #(
   parameter int W = 64,
   parameter int D = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   generate
      if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
         $error("fifo depth must be a power of two");
      end
   endgenerate
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
   logic [AW:0] count_ff, nxt_count;
   logic ready_ff, valid_ff;
   logic push, pop;
   assign push = in_valid && ready_ff;
   assign pop = valid_ff && out_ready;
   assign in_ready = ready_ff;
   assign out_valid = valid_ff;
   assign out_data = mem[rd_ptr_ff];
   always_comb begin
      nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
         ready_ff <= 1'b0;
         valid_ff <= 1'b0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + AW'(push);
         rd_ptr_ff <= rd_ptr_ff + AW'(pop);
         count_ff <= nxt_count;
         ready_ff <= nxt_count < (AW+1)'(D);
         valid_ff <= nxt_count != '0;
      end
   end
   a_fifo_bounds: assert property (@(posedge clk_sys) disable iff (reset)
      count_ff <= (AW+1)'(D) && (valid_ff == (count_ff != '0)))
      else $error("fifo count out of range");
endmodule

// ****************************************
// Frame and processing control
// ****************************************
module rfdc_top
   import rfdc_pkg::*;
#(
   parameter int SETTLE_CYC = SETTLE_CYC_DEF,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic strap_sel_hi_drv,
   input wire logic strap_sel_hi_lvl,
   input wire logic strap_sel_lo_drv,
   input wire logic strap_sel_lo_lvl,
   input wire logic strap_run_drv,
   input wire logic strap_run_lvl,
   input wire logic cfg_access,
   input wire logic [15:0] t_pre_cyc,
   input wire logic [15:0] chirp_len_cyc,
   input wire logic [7:0] chirp_num,
   input wire logic [15:0] frame_idle_interval,
   input wire logic pwr_gate_off,
   input wire logic cw_mode,
   input wire logic [9:0] chirp_dev_mhz,
   input wire logic [9:0] chirp_step,
   input wire logic cascade_master,
   input wire logic sync_in,
   input wire rfdc_fmt_t out_fmt,
   input wire rfdc_dec_t dec_rate,
   input wire rfdc_win_t win_kind,
   input wire rfdc_rsz_t range_size,
   input wire logic doppler_en,
   input wire logic [2:0] doppler_arr,
   input wire logic cfar_report_en,
   input wire logic [8:0] samples_per_chirp,
   input wire logic [8:0] zp_start,
   input wire logic [8:0] zp_end,
   input wire logic zone_en,
   input wire logic [15:0] zone_thresh,
   input wire logic adc_valid,
   input wire logic [15:0] adc_i1,
   input wire logic [15:0] adc_q1,
   input wire logic [15:0] adc_i2,
   input wire logic [15:0] adc_q2,
   input wire logic [9:0] temp_adc,
   input wire logic [9:0] pdet_adc,
   output logic sample_ready,
   output logic data_valid,
   input wire logic data_ready,
   output logic [63:0] data_out,
   output logic straps_done_ff,
   output logic standby_ff,
   output rfdc_chan_t chan_sel_ff,
   output logic cfar_to_data_chan_ff,
   output logic cfg_error_ff,
   output logic wavegen_init_ff,
   output logic chirp_active_ff,
   output logic [9:0] chirp_freq_ff,
   output logic rf_power_on_ff,
   output logic sync_out_ff,
   output logic lo_share_output_ff,
   output logic zone_out_nearest_ff,
   output logic zone_out_second_ff,
   output logic zone_out_third_ff,
   output logic zone_out_farthest_ff,
   output logic [9:0] temp_reading_ff,
   output logic [9:0] pdet_reading_ff
);
   generate
      if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
         $error("settle count out of range");
      end
   endgenerate

   function automatic logic [3:0] rsz_log2(input rfdc_rsz_t s);
      case (s)
         RFDC_RSZ_64: rsz_log2 = 4'h6;
         RFDC_RSZ_128: rsz_log2 = 4'h7;
         default: rsz_log2 = 4'h8;
      endcase
   endfunction

   function automatic logic [15:0] hpf(input logic [15:0] x, input logic [15:0] xp, input logic [15:0] yp);
      hpf = x - xp + yp - 16'($signed(yp) >>> HPF_SHIFT);
   endfunction

   function automatic logic [8:0] wcoef(input rfdc_win_t k, input logic [8:0] idx, input logic [3:0] lg);
      logic [8:0] n;
      logic [17:0] p;
      logic [8:0] pq;
      logic [17:0] t;
      n = 9'h001 << lg;
      p = 18'(idx) * 18'(n - idx);
      pq = 9'(p >> (2 * lg - 10));
      case (k)
         RFDC_WIN_HANN: wcoef = pq;
         RFDC_WIN_HAMM: begin
            t = 18'(pq) * 18'(HAMM_SLOPE);
            wcoef = HAMM_PED + 9'(t >> 8);
         end
         RFDC_WIN_BLACK: begin
            t = 18'(pq) * 18'(pq);
            wcoef = 9'(t >> 8);
         end
         default: wcoef = WIN_UNITY;
      endcase
   endfunction

   function automatic logic [15:0] wmul(input logic [15:0] x, input logic [8:0] c);
      logic signed [25:0] m;
      m = $signed({{10{x[15]}}, x}) * $signed({17'h00000, c});
      wmul = 16'(m >>> 8);
   endfunction

   // ****************************************
   // Straps and standby
   // ****************************************
   logic [2:0] strap_s1_ff, strap_s2_ff;
   logic [15:0] settle_cnt_ff;
   // Run strap floats low so a bare board stays in standby
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         strap_s1_ff <= 3'h0;
         strap_s2_ff <= 3'h0;
      end else begin
         strap_s1_ff <= {strap_sel_hi_drv ? strap_sel_hi_lvl : 1'b1,
                         strap_sel_lo_drv ? strap_sel_lo_lvl : 1'b1,
                         strap_run_drv && strap_run_lvl};
         strap_s2_ff <= strap_s1_ff;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         settle_cnt_ff <= CNT_RST;
         straps_done_ff <= 1'b0;
         chan_sel_ff <= RFDC_CH_UART;
         standby_ff <= 1'b1;
      end else if (!straps_done_ff) begin
         settle_cnt_ff <= settle_cnt_ff + 16'h0001;
         if (settle_cnt_ff == 16'(SETTLE_CYC - 1)) begin
            straps_done_ff <= 1'b1;
            chan_sel_ff <= rfdc_chan_t'(strap_s2_ff[2:1]);
            standby_ff <= !strap_s2_ff[0] && !cfg_access;
         end
      end else if (cfg_access) begin
         standby_ff <= 1'b0;
      end
   end

   a_strap_hold: assert property (@(posedge clk_sys) disable iff (reset)
      straps_done_ff |=> straps_done_ff && $stable(chan_sel_ff))
      else $error("latched strap state changed");
   a_standby_exit: assert property (@(posedge clk_sys) disable iff (reset)
      straps_done_ff && cfg_access |=> !standby_ff)
      else $error("standby not left on config access");
   a_chan_decode: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(straps_done_ff) |-> chan_sel_ff == rfdc_chan_t'($past(strap_s2_ff[2:1])))
      else $error("channel select not decoded from straps");

   // ****************************************
   // Frame sequencer
   // ****************************************
   rfdc_frame_t state_ff, nxt_state;
   logic [15:0] cnt_ff;
   logic [7:0] chirp_idx_ff;
   logic sync_s1_ff, sync_s2_ff, sync_s3_ff;
   logic go, pre_end, chirp_end, idle_end, gate_ok;
   logic [15:0] t_pre_m1, clen_m1, idle_m1;
   assign t_pre_m1 = (t_pre_cyc == CNT_RST) ? CNT_RST : t_pre_cyc - 16'h0001;
   assign clen_m1 = (chirp_len_cyc == CNT_RST) ? CNT_RST : chirp_len_cyc - 16'h0001;
   assign idle_m1 = (frame_idle_interval == CNT_RST) ? CNT_RST : frame_idle_interval - 16'h0001;
   // Slaves follow the master's frame start pulse
   assign go = straps_done_ff && !standby_ff && (cascade_master || (sync_s2_ff && !sync_s3_ff));
   assign pre_end = state_ff == FR_PRE && cnt_ff == t_pre_m1;
   assign chirp_end = state_ff == FR_CHIRP && !cw_mode && cnt_ff == clen_m1;
   assign idle_end = state_ff == FR_IDLE && cnt_ff == idle_m1;
   // Strictly longer than two transitions, so the off window is never empty
   assign gate_ok = !pwr_gate_off && {1'b0, frame_idle_interval} > {POWER_TRANSITION_TIME_C, 1'b0};

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync_s1_ff <= 1'b0;
         sync_s2_ff <= 1'b0;
         sync_s3_ff <= 1'b0;
      end else begin
         sync_s1_ff <= sync_in;
         sync_s2_ff <= sync_s1_ff;
         sync_s3_ff <= sync_s2_ff;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         FR_HALT: if (go) nxt_state = FR_PRE;
         FR_PRE: if (pre_end) nxt_state = FR_CHIRP;
         FR_CHIRP: if (chirp_end && chirp_idx_ff == chirp_num - 8'h01) nxt_state = FR_IDLE;
         FR_IDLE: if (idle_end) nxt_state = FR_HALT;
         default: nxt_state = FR_HALT;
      endcase
      if (standby_ff) begin
         nxt_state = FR_HALT;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_ff <= FR_HALT;
         cnt_ff <= CNT_RST;
         chirp_idx_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         if (nxt_state != state_ff || chirp_end) begin
            cnt_ff <= CNT_RST;
         end else begin
            cnt_ff <= cnt_ff + 16'h0001;
         end
         if (state_ff != FR_CHIRP) begin
            chirp_idx_ff <= 8'h00;
         end else if (chirp_end) begin
            chirp_idx_ff <= chirp_idx_ff + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wavegen_init_ff <= 1'b0;
         chirp_active_ff <= 1'b0;
         sync_out_ff <= 1'b0;
         lo_share_output_ff <= 1'b0;
      end else begin
         wavegen_init_ff <= nxt_state == FR_PRE;
         chirp_active_ff <= nxt_state == FR_CHIRP;
         sync_out_ff <= cascade_master && state_ff == FR_HALT && nxt_state == FR_PRE;
         lo_share_output_ff <= cascade_master && straps_done_ff;
      end
   end

   // Deviation clamps at the top; CW holds the carrier
   logic [9:0] dev_lim;
   assign dev_lim = (chirp_dev_mhz > MAX_DEV) ? MAX_DEV : chirp_dev_mhz;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         chirp_freq_ff <= FREQ_RST;
      end else if (state_ff != FR_CHIRP || cw_mode || chirp_end) begin
         chirp_freq_ff <= FREQ_RST;
      end else if ({1'b0, chirp_freq_ff} + {1'b0, chirp_step} >= {1'b0, dev_lim}) begin
         chirp_freq_ff <= dev_lim;
      end else begin
         chirp_freq_ff <= chirp_freq_ff + chirp_step;
      end
   end

   // Off window leaves a full transition at both ends of idle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rf_power_on_ff <= 1'b0;
      end else if (state_ff == FR_IDLE && gate_ok) begin
         rf_power_on_ff <= !(cnt_ff >= POWER_TRANSITION_TIME_C && cnt_ff < frame_idle_interval - POWER_TRANSITION_TIME_C);
      end else begin
         rf_power_on_ff <= !standby_ff;
      end
   end

   a_pre_to_chirp: assert property (@(posedge clk_sys) disable iff (reset)
      state_ff == FR_PRE && !standby_ff |=>
         chirp_active_ff == $past(pre_end) && wavegen_init_ff == !$past(pre_end))
      else $error("preparation interval length wrong");
   a_no_chirp_in_pre: assert property (@(posedge clk_sys) disable iff (reset)
      state_ff == FR_HALT |=> state_ff != FR_CHIRP)
      else $error("chirp without preparation");
   a_power_gate: assert property (@(posedge clk_sys) disable iff (reset)
      state_ff == FR_IDLE && gate_ok && cnt_ff == POWER_TRANSITION_TIME_C |=> !rf_power_on_ff)
      else $error("RF not powered down in idle");
   a_power_back: assert property (@(posedge clk_sys) disable iff (reset)
      state_ff == FR_PRE && !standby_ff |-> rf_power_on_ff)
      else $error("RF off during preparation");

   // ****************************************
   // Sample processing
   // ****************************************
   logic [2:0] dec_cnt_ff, dec_mask;
   logic [8:0] s_idx_ff;
   logic [15:0] xp_ff [4], yp_ff [4];
   logic [15:0] lane_in [4], lane_hp [4], lane_out [4];
   logic [3:0] zhit_ff;
   logic raw_path, keep, in_zone2, take, fifo_in_ready;
   logic [8:0] wc;
   logic [3:0] lg;
   logic [1:0] zone_of;
   assign raw_path = out_fmt == RFDC_FMT_DECIMATED_RAW;
   assign dec_mask = (3'h1 << dec_rate) - 3'h1;
   assign keep = adc_valid && chirp_active_ff && (dec_cnt_ff & dec_mask) == 3'h0;
   assign in_zone2 = s_idx_ff >= zp_start && s_idx_ff < zp_end;
   assign take = keep && fifo_in_ready && s_idx_ff < samples_per_chirp;
   assign lg = rsz_log2(range_size);
   assign wc = wcoef(win_kind, s_idx_ff, lg);
   assign zone_of = 2'(s_idx_ff >> (lg - 4'h2));
   assign lane_in[0] = adc_i1;
   assign lane_in[1] = adc_q1;
   assign lane_in[2] = adc_i2;
   assign lane_in[3] = adc_q2;

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         lane_hp[k] = hpf(lane_in[k], xp_ff[k], yp_ff[k]);
         if (raw_path) begin
            lane_out[k] = lane_in[k];
         end else if (!in_zone2) begin
            lane_out[k] = 16'h0000;
         end else begin
            lane_out[k] = wmul(lane_hp[k], wc);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset || !chirp_active_ff) begin
         dec_cnt_ff <= 3'h0;
         s_idx_ff <= 9'h000;
         for (int k = 0; k < 4; k++) begin
            xp_ff[k] <= 16'h0000;
            yp_ff[k] <= 16'h0000;
         end
      end else if (adc_valid && (!keep || take)) begin
         dec_cnt_ff <= dec_cnt_ff + 3'h1;
         if (take) begin
            s_idx_ff <= s_idx_ff + 9'h001;
            for (int k = 0; k < 4; k++) begin
               xp_ff[k] <= lane_in[k];
               yp_ff[k] <= lane_hp[k];
            end
         end
      end
   end

   // Zones refresh once per chirp so outputs do not flicker
   always_ff @(posedge clk_sys) begin
      if (reset || !zone_en) begin
         zhit_ff <= ZONE_RST;
         {zone_out_farthest_ff, zone_out_third_ff, zone_out_second_ff, zone_out_nearest_ff} <= ZONE_RST;
      end else if (chirp_end) begin
         {zone_out_farthest_ff, zone_out_third_ff, zone_out_second_ff, zone_out_nearest_ff} <= zhit_ff;
         zhit_ff <= ZONE_RST;
      end else if (take && !raw_path && in_zone2 &&
                   ($signed(lane_out[0]) > $signed(zone_thresh) || -$signed(lane_out[0]) > $signed(zone_thresh))) begin
         zhit_ff[zone_of] <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg_error_ff <= 1'b0;
         cfar_to_data_chan_ff <= 1'b0;
         temp_reading_ff <= 10'h000;
         pdet_reading_ff <= 10'h000;
      end else begin
         cfg_error_ff <= range_size == RFDC_RSZ_BAD || (doppler_en && doppler_arr > DOP_LAST);
         cfar_to_data_chan_ff <= cfar_report_en && doppler_en && out_fmt == RFDC_FMT_CFAR &&
                                 chan_sel_ff != RFDC_CH_I2C;
         temp_reading_ff <= temp_adc;
         pdet_reading_ff <= pdet_adc;
      end
   end

   a_zero_pad: assert property (@(posedge clk_sys) disable iff (reset)
      take && !raw_path && !in_zone2 |-> lane_out[0] == 16'h0000 && lane_out[3] == 16'h0000)
      else $error("outer zone sample not zeroed");
   a_zone_disabled: assert property (@(posedge clk_sys) disable iff (reset)
      !zone_en |=> !zone_out_nearest_ff && !zone_out_farthest_ff)
      else $error("zone output high while disabled");
   a_decim_rate: assert property (@(posedge clk_sys) disable iff (reset)
      take |-> (dec_cnt_ff & dec_mask) == 3'h0)
      else $error("sample taken off decimation phase");

   rfdc_fifo #(.W(64), .D(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(take),
      .in_ready(fifo_in_ready),
      .in_data({lane_out[3], lane_out[2], lane_out[1], lane_out[0]}),
      .out_valid(data_valid),
      .out_ready(data_ready),
      .out_data(data_out)
   );
   assign sample_ready = fifo_in_ready;
endmodule

// >>> verification/rfdc_host_model.sv
module rfdc_host_model (
   input wire logic clk_sys,
   input wire logic straps_done_ff,
   input wire logic [2:0] cfg_lvl,
   input wire logic [2:0] cfg_drv,
   input wire logic stall,
   output logic strap_sel_hi_drv,
   output logic strap_sel_hi_lvl,
   output logic strap_sel_lo_drv,
   output logic strap_sel_lo_lvl,
   output logic strap_run_drv,
   output logic strap_run_lvl,
   output logic data_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] drv;
   // Straps let go once latched; lines fall back to their pulls
   assign drv = straps_done_ff ? 3'h0 : cfg_drv;
   assign strap_sel_hi_drv = drv[2];
   assign strap_sel_lo_drv = drv[1];
   assign strap_run_drv = drv[0];
   assign strap_sel_hi_lvl = drv[2] ? cfg_lvl[2] : 1'b1;
   assign strap_sel_lo_lvl = drv[1] ? cfg_lvl[1] : 1'b1;
   assign strap_run_lvl = drv[0] ? cfg_lvl[0] : 1'b0;
   // Random stalls keep the buffer both filling and draining
   always @(negedge clk_sys) begin
      data_ready <= stall ? 1'b0 : 1'($urandom_range(1));
   end
endmodule

// >>> verification/testbench.sv
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
   $display("BAD %s exp %0h got %0h", what, exp, got); end end
module testbench
   import rfdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0, reset = 1'b1, cfg_access = 1'b0, pwr_gate_off = 1'b1, cw_mode = 1'b0, sync_in = 1'b0;
   logic cascade_master = 1'b1, doppler_en = 1'b0, cfar_report_en = 1'b0, zone_en = 1'b0, adc_valid = 1'b0;
   logic stall = 1'b1;
   logic [15:0] t_pre_cyc = 16'h0005, chirp_len_cyc = 16'h0003, frame_idle_interval = 16'h0004;
   logic [15:0] zone_thresh = 16'h0100, adc_i1 = 16'h0000, adc_q1 = 16'h0000, adc_i2 = 16'h0000, adc_q2 = 16'h0000;
   logic [7:0] chirp_num = 8'h02;
   logic [9:0] chirp_dev_mhz = 10'h064, chirp_step = 10'h00a, temp_adc = 10'h000, pdet_adc = 10'h000;
   logic [8:0] samples_per_chirp = 9'h1ff, zp_start = 9'h000, zp_end = 9'h1ff;
   logic [2:0] doppler_arr = 3'h0, cfg_lvl = 3'h7, cfg_drv = 3'h7;
   rfdc_fmt_t out_fmt = RFDC_FMT_DECIMATED_RAW;
   rfdc_dec_t dec_rate = RFDC_DEC_1;
   rfdc_win_t win_kind = RFDC_WIN_RECT;
   rfdc_rsz_t range_size = RFDC_RSZ_64;
   rfdc_chan_t chan_sel_ff;
   logic strap_sel_hi_drv, strap_sel_hi_lvl, strap_sel_lo_drv, strap_sel_lo_lvl, strap_run_drv, strap_run_lvl;
   logic data_ready, sample_ready, data_valid, straps_done_ff, standby_ff, cfar_to_data_chan_ff, cfg_error_ff;
   logic wavegen_init_ff, chirp_active_ff, rf_power_on_ff, sync_out_ff, lo_share_output_ff;
   logic zone_out_nearest_ff, zone_out_second_ff, zone_out_third_ff, zone_out_farthest_ff;
   logic [63:0] data_out;
   logic [9:0] chirp_freq_ff, temp_reading_ff, pdet_reading_ff;
   int n_errors = 0, tests_run = 0, i, n;
   logic [63:0] q[$], exp_w;

   rfdc_top #(.SETTLE_CYC(4), .FIFO_DEPTH(16)) rfdc_top_i (.*);
   rfdc_host_model rfdc_host_model_i (.*);

   always #12.5 clk_sys = ~clk_sys;

   // ****************************************
   // Stream model
   // ****************************************
   // Read before the edge's updates land, as the design sees them
   always @(posedge clk_sys) begin
      if (!reset && adc_valid && sample_ready && chirp_active_ff) begin
         q.push_back({adc_q2, adc_i2, adc_q1, adc_i1});
      end
      if (!reset && data_valid && data_ready) begin
         exp_w = q.pop_front();
         `CHK("data", exp_w, data_out)
      end
   end
   always @(negedge clk_sys) begin
      adc_i1 <= 16'($urandom);
      adc_q1 <= 16'($urandom);
      adc_i2 <= 16'($urandom);
      adc_q2 <= 16'($urandom);
   end

   task automatic close_out;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic power_up(input logic [2:0] lvl, input logic [2:0] drv);
      cfg_lvl = lvl;
      cfg_drv = drv;
      reset = 1'b1;
      repeat (4) @(negedge clk_sys);
      reset = 1'b0;
      for (n = 0; n < 50 && straps_done_ff !== 1'b1; n++) @(negedge clk_sys);
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      void'($urandom(32'hcb844914));
      temp_adc = 10'($urandom);
      pdet_adc = 10'($urandom);
      for (i = 0; i < 4; i++) begin
         power_up({i[1:0], 1'b1}, 3'h7);
         `CHK("chan", rfdc_chan_t'(i[1:0]), chan_sel_ff)
         `CHK("standby", 1'b0, standby_ff)
         // Straps now float to the pull levels; latched values must hold
         repeat (6) @(negedge clk_sys);
         `CHK("chan held", rfdc_chan_t'(i[1:0]), chan_sel_ff)
         `CHK("standby held", 1'b0, standby_ff)
      end
      power_up(3'h0, 3'h0);
      `CHK("float chan", RFDC_CH_RSVD, chan_sel_ff)
      `CHK("float standby", 1'b1, standby_ff)
      cfg_access = 1'b1;
      @(negedge clk_sys);
      cfg_access = 1'b0;
      @(negedge clk_sys);
      `CHK("wake", 1'b0, standby_ff)
      power_up(3'b101, 3'h7);
      for (n = 0; n < 100 && wavegen_init_ff !== 1'b1; n++) @(negedge clk_sys);
      `CHK("sync", 1'b1, sync_out_ff)
      `CHK("lo share", 1'b1, lo_share_output_ff)
      for (n = 0; n < 100 && wavegen_init_ff === 1'b1; n++) @(negedge clk_sys);
      `CHK("prep", int'(t_pre_cyc), n)
      for (n = 0; n < 100 && chirp_active_ff === 1'b1; n++) @(negedge clk_sys);
      `CHK("chirps", int'(chirp_num) * int'(chirp_len_cyc), n)
      for (n = 0; n < 100 && wavegen_init_ff === 1'b0 && chirp_active_ff === 1'b0; n++) @(negedge clk_sys);
      `CHK("idle", int'(frame_idle_interval) + 1, n)
      // Far side stalled: buffer must fill to its depth, then refuse
      adc_valid = 1'b1;
      for (n = 0; n < 3000 && sample_ready !== 1'b0; n++) @(negedge clk_sys);
      `CHK("fill", 16, q.size())
      stall = 1'b0;
      for (n = 0; n < 3000 && q.size() != 0; n++) @(negedge clk_sys);
      adc_valid = 1'b0;
      repeat (40) @(negedge clk_sys);
      `CHK("drained", 0, q.size())
      `CHK("zones", 4'h0, {zone_out_nearest_ff, zone_out_second_ff, zone_out_third_ff, zone_out_farthest_ff})
      `CHK("temp", temp_adc, temp_reading_ff)
      `CHK("pdet", pdet_adc, pdet_reading_ff)
      cfar_report_en = 1'b1;
      doppler_en = 1'b1;
      out_fmt = RFDC_FMT_CFAR;
      range_size = RFDC_RSZ_BAD;
      repeat (2) @(negedge clk_sys);
      `CHK("cfar", 1'b1, cfar_to_data_chan_ff)
      `CHK("size bad", 1'b1, cfg_error_ff)
      range_size = RFDC_RSZ_256;
      doppler_arr = 3'h5;
      repeat (2) @(negedge clk_sys);
      `CHK("arr bad", 1'b1, cfg_error_ff)
      doppler_arr = 3'h4;
      repeat (2) @(negedge clk_sys);
      `CHK("arr ok", 1'b0, cfg_error_ff)
      // Long idle lets the gate open; deviation asked above the limit
      chirp_dev_mhz = 10'h3ff;
      chirp_len_cyc = 16'h00c8;
      frame_idle_interval = 16'h0fa0;
      pwr_gate_off = 1'b0;
      for (n = 0; n < 5000 && chirp_active_ff !== 1'b0; n++) @(negedge clk_sys);
      repeat (1500) @(negedge clk_sys);
      `CHK("gated", 1'b0, rf_power_on_ff)
      for (n = 0; n < 5000 && wavegen_init_ff !== 1'b1; n++) @(negedge clk_sys);
      `CHK("ungated", 1'b1, rf_power_on_ff)
      for (n = 0; n < 100 && chirp_active_ff !== 1'b1; n++) @(negedge clk_sys);
      repeat (150) @(negedge clk_sys);
      `CHK("clamp", MAX_DEV, chirp_freq_ff)
      cw_mode = 1'b1;
      repeat (2) @(negedge clk_sys);
      `CHK("cw", 10'h000, chirp_freq_ff)
      close_out();
   end

   initial begin
      #(25 * 40000);
      n_errors++;
      close_out();
   end
endmodule
